// *** derived_channel_consts.svh ***
`ifndef DERIVED_CHANNEL_CONSTS_SVH
`define DERIVED_CHANNEL_CONSTS_SVH

// Sample and coefficient widths
`define DC_DATA_W      24
`define DC_RES_W       32
`define DC_GAIN_W      16
`define DC_GAIN_FRAC   14
`define DC_QUO_FRAC    16
`define DC_DIV_STEPS   6'd40

// Register byte offsets
`define DC_OFF_CTRL    8'h00
`define DC_OFF_GAIN1   8'h04
`define DC_OFF_OFFS1   8'h08
`define DC_OFF_GAIN2   8'h0C
`define DC_OFF_OFFS2   8'h10
`define DC_OFF_COMMIT  8'h14
`define DC_OFF_STATUS  8'h18
`define DC_OFF_MASK    8'h1C
`define DC_OFF_RESULT  8'h20

// Field positions
`define DC_CTRL_OP_LSB 0
`define DC_CTRL_ORDER  2
`define DC_ST_DONE     0
`define DC_ST_DIVSAT   1
`define DC_ST_SCLSAT   2

// Reset values and fixed results
`define DC_GAIN_ONE    16'h4000
`define DC_OFFS_ZERO   24'h000000
`define DC_ONE_Q16     32'h00010000
`define DC_TWO_Q16     32'h00020000
`define DC_SAT_POS     32'h7FFFFFFF
`define DC_SAT_NEG     32'h80000000

`endif

// *** derived_channel_pkg.sv ***
`default_nettype none
package derived_channel_pkg;

  typedef enum logic [1:0] {
    OP_SUB   = 2'b00,
    OP_DIV   = 2'b01,
    OP_RATIO = 2'b10
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b10
  } state_e;

  typedef struct packed {
    logic               valid;
    logic signed [23:0] ch1;
    logic signed [23:0] ch2;
    logic signed [23:0] temp;
  } sample_s;

  typedef struct packed {
    logic               valid;
    logic signed [23:0] ch1;
    logic signed [23:0] ch2;
    logic signed [23:0] temp;
    logic signed [31:0] ch3;
  } result_s;

endpackage : derived_channel_pkg
`default_nettype wire

// *** derived_channel_and_output_scaling.sv ***
// What this block does
// - Derived channel uses only conditioned first and second channel values.
// - Control field selects subtraction, division or ratio.
// - Order bit swaps which channel is left and which right operand for subtraction and division.
// - Subtraction gives first minus second, or second minus first reversed.
// - Division gives first over second, or second over first reversed.
// - Zero or tiny divisor clamps a division to saturation and gives 2 minus saturation for ratio, never faults.
// - Ratio: equal gives 1, smaller first gives a/b, else 2 minus b/a.
// - Derived result is a full four-byte word, Q16.16 for division and ratio.
// - Main channels are scaled linearly: gain multiply, then add offset.
// - Only main channels scale; temperature and derived pass through.
// - Scaler sits between conditioning math input and IIR filter output.
// - Coefficients come from the nonvolatile copy, used once committed.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`include "derived_channel_consts.svh"
`default_nettype none
module derived_channel_and_output_scaling #(
  parameter logic [23:0] SMALL_DIV = 24'h000004
) (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            ce,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic                                 hreadyout,
  output logic                                 hresp,
  output logic [31:0]                          hrdata,
  input  wire derived_channel_pkg::sample_s    in_sample,
  output logic                                 in_ready,
  output derived_channel_pkg::result_s         out_result,
  output logic                                 irq
);

  // Bus slave: zero wait states, every access OKAY
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic [2:0]  ctrl_q;
  logic [15:0] gain1_nv_q, gain2_nv_q, gain1_q, gain2_q;
  logic [23:0] offs1_nv_q, offs2_nv_q, offs1_q, offs2_q;
  logic [2:0]  status_q, mask_q;
  logic        irq_q;

  wire        addr_ph  = hsel && htrans[1] && hready;
  wire        rd_ph    = addr_ph && !hwrite;
  wire [7:0]  rd_addr  = haddr[7:0];
  wire        wr_now   = wr_pend_q;
  wire        wr_ctrl  = wr_now && wr_addr_q == `DC_OFF_CTRL;
  wire        wr_g1    = wr_now && wr_addr_q == `DC_OFF_GAIN1;
  wire        wr_o1    = wr_now && wr_addr_q == `DC_OFF_OFFS1;
  wire        wr_g2    = wr_now && wr_addr_q == `DC_OFF_GAIN2;
  wire        wr_o2    = wr_now && wr_addr_q == `DC_OFF_OFFS2;
  wire        wr_cmt   = wr_now && wr_addr_q == `DC_OFF_COMMIT && hwdata[0];
  wire        wr_stat  = wr_now && wr_addr_q == `DC_OFF_STATUS;
  wire        wr_mask  = wr_now && wr_addr_q == `DC_OFF_MASK;
  wire [2:0]  stat_clr = wr_stat ? hwdata[2:0] : 3'h0;

  logic [31:0] res_q;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (rd_addr)
      `DC_OFF_CTRL:   rd_mux = {29'h0, ctrl_q};
      `DC_OFF_GAIN1:  rd_mux = {16'h0, gain1_nv_q};
      `DC_OFF_OFFS1:  rd_mux = {{8{offs1_nv_q[23]}}, offs1_nv_q};
      `DC_OFF_GAIN2:  rd_mux = {16'h0, gain2_nv_q};
      `DC_OFF_OFFS2:  rd_mux = {{8{offs2_nv_q[23]}}, offs2_nv_q};
      `DC_OFF_STATUS: rd_mux = {29'h0, status_q};
      `DC_OFF_MASK:   rd_mux = {29'h0, mask_q};
      `DC_OFF_RESULT: rd_mux = res_q;
      default:        rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hreadyout_q <= 1'b0;
      hrdata_q    <= 32'h0;
    end else if (ce) begin
      wr_pend_q   <= addr_ph && hwrite;
      wr_addr_q   <= haddr[7:0];
      hreadyout_q <= 1'b1;
      hrdata_q    <= rd_ph ? rd_mux : 32'h0;
    end
  end

  // Software edits the nonvolatile copy; the datapath sees it after commit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q     <= 3'h0;
      gain1_nv_q <= `DC_GAIN_ONE;
      gain2_nv_q <= `DC_GAIN_ONE;
      offs1_nv_q <= `DC_OFFS_ZERO;
      offs2_nv_q <= `DC_OFFS_ZERO;
      mask_q     <= 3'h0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= hwdata[2:0];
      if (wr_g1) gain1_nv_q <= hwdata[15:0];
      if (wr_o1) offs1_nv_q <= hwdata[23:0];
      if (wr_g2) gain2_nv_q <= hwdata[15:0];
      if (wr_o2) offs2_nv_q <= hwdata[23:0];
      if (wr_mask) mask_q <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain1_q <= `DC_GAIN_ONE;
      gain2_q <= `DC_GAIN_ONE;
      offs1_q <= `DC_OFFS_ZERO;
      offs2_q <= `DC_OFFS_ZERO;
    end else if (ce && wr_cmt) begin
      gain1_q <= gain1_nv_q;
      gain2_q <= gain2_nv_q;
      offs1_q <= offs1_nv_q;
      offs2_q <= offs2_nv_q;
    end
  end

  // Scaler: x * gain (Q2.14) then + offset, clamped to the sample range
  function automatic logic [24:0] scale(input logic signed [23:0] x,
                                        input logic [15:0]        g,
                                        input logic signed [23:0] o);
    logic signed [40:0] prod;
    logic signed [41:0] sum;
    prod = x * $signed({1'b0, g});
    sum  = 42'(prod >>> `DC_GAIN_FRAC) + 42'(o);
    if (sum > 42'sh7FFFFF) scale = {1'b1, 24'h7FFFFF};
    else if (sum < -42'sh800000) scale = {1'b1, 24'h800000};
    else scale = {1'b0, sum[23:0]};
  endfunction : scale

  wire [24:0] sc1 = scale(in_sample.ch1, gain1_q, offs1_q);
  wire [24:0] sc2 = scale(in_sample.ch2, gain2_q, offs2_q);

  // Operand selection for the derived channel
  derived_channel_pkg::op_e op;
  assign op = derived_channel_pkg::op_e'(ctrl_q[`DC_CTRL_OP_LSB +: 2]);
  wire        rev   = ctrl_q[`DC_CTRL_ORDER];
  wire signed [23:0] a = in_sample.ch1;
  wire signed [23:0] b = in_sample.ch2;
  wire        is_ratio = op == derived_channel_pkg::OP_RATIO;
  wire        is_div   = op == derived_channel_pkg::OP_DIV;
  wire        r_eq     = a == b;
  wire        r_lt     = a < b;
  wire signed [23:0] lop = is_ratio ? (r_lt ? a : b) : (rev ? b : a);
  wire signed [23:0] rop = is_ratio ? (r_lt ? b : a) : (rev ? a : b);
  wire signed [24:0] diff = 25'(lop) - 25'(rop);
  wire [23:0] l_abs = lop[23] ? 24'(-lop) : lop;
  wire [23:0] r_abs = rop[23] ? 24'(-rop) : rop;
  wire        q_neg = lop[23] ^ rop[23];
  wire        tiny  = r_abs < SMALL_DIV;
  wire [31:0] sat_v = q_neg ? `DC_SAT_NEG : `DC_SAT_POS;

  // Sequencer: one sample at a time, long division one bit per cycle
  derived_channel_pkg::state_e state_q;
  logic [39:0] quo_q;
  logic [24:0] rem_q;
  logic [23:0] den_q;
  logic [5:0]  cnt_q;
  logic        neg_q, two_q, in_ready_q;
  logic [23:0] h1_q, h2_q, ht_q;
  derived_channel_pkg::result_s out_q;

  wire        accept = in_sample.valid && in_ready_q;
  wire [24:0] trial  = {rem_q[23:0], quo_q[39]};
  wire        ge     = trial >= {1'b0, den_q};
  wire [39:0] quo_n  = {quo_q[38:0], ge};
  wire        q_ovf  = |quo_n[39:31];
  wire [31:0] q_sgn  = neg_q ? 32'(-quo_n[31:0]) : quo_n[31:0];
  wire [31:0] q_sat  = neg_q ? `DC_SAT_NEG : `DC_SAT_POS;
  wire [31:0] q_fin  = q_ovf ? q_sat : q_sgn;
  wire [31:0] q_res  = two_q ? 32'(`DC_TWO_Q16 - q_fin) : q_fin;
  wire        last   = cnt_q == `DC_DIV_STEPS - 6'd1;
  wire        fin    = (state_q == derived_channel_pkg::ST_DIV) && last;

  // Immediate results: subtraction, equal ratio, saturated divide
  logic [31:0] imm_v;
  logic        imm_ok, imm_sat;
  always_comb begin
    imm_ok  = 1'b1;
    imm_sat = 1'b0;
    imm_v   = 32'(signed'(diff));
    if (is_ratio && r_eq) begin
      imm_v = `DC_ONE_Q16;
    end else if (is_ratio || is_div) begin
      if (tiny) begin
        imm_sat = 1'b1;
        imm_v   = is_ratio ? 32'(`DC_TWO_Q16 - sat_v) : sat_v;
      end else begin
        imm_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= derived_channel_pkg::ST_IDLE;
      in_ready_q <= 1'b0;
      quo_q      <= 40'h0;
      rem_q      <= 25'h0;
      den_q      <= 24'h0;
      cnt_q      <= 6'h0;
      neg_q      <= 1'b0;
      two_q      <= 1'b0;
      h1_q       <= 24'h0;
      h2_q       <= 24'h0;
      ht_q       <= 24'h0;
      res_q      <= 32'h0;
    end else if (ce) begin
      unique case (state_q)
        derived_channel_pkg::ST_IDLE: begin
          in_ready_q <= 1'b1;
          if (accept) begin
            in_ready_q <= 1'b0;
            h1_q  <= sc1[23:0];
            h2_q  <= sc2[23:0];
            ht_q  <= in_sample.temp;
            quo_q <= {l_abs, 16'h0};
            rem_q <= 25'h0;
            den_q <= r_abs;
            cnt_q <= 6'h0;
            neg_q <= q_neg;
            two_q <= is_ratio && !r_lt;
            if (imm_ok) begin
              res_q   <= imm_v;
              state_q <= derived_channel_pkg::ST_DONE;
            end else begin
              state_q <= derived_channel_pkg::ST_DIV;
            end
          end
        end
        derived_channel_pkg::ST_DIV: begin
          quo_q <= quo_n;
          rem_q <= ge ? trial - {1'b0, den_q} : trial;
          cnt_q <= cnt_q + 6'd1;
          if (last) begin
            res_q   <= q_res;
            state_q <= derived_channel_pkg::ST_DONE;
          end
        end
        derived_channel_pkg::ST_DONE: begin
          in_ready_q <= 1'b1;
          state_q    <= derived_channel_pkg::ST_IDLE;
        end
        default: state_q <= derived_channel_pkg::ST_IDLE;
      endcase
    end
  end

  wire done_ev = state_q == derived_channel_pkg::ST_DONE;

  // Output word towards the filter: one-cycle valid, no back-pressure
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= '0;
    end else if (ce) begin
      out_q.valid <= done_ev;
      if (done_ev) begin
        out_q.ch1  <= h1_q;
        out_q.ch2  <= h2_q;
        out_q.temp <= ht_q;
        out_q.ch3  <= res_q;
      end
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  wire [2:0] ev_set;
  assign ev_set[`DC_ST_DONE]   = done_ev;
  assign ev_set[`DC_ST_DIVSAT] = (accept && imm_ok && imm_sat) ||
                                 (fin && q_ovf);
  assign ev_set[`DC_ST_SCLSAT] = accept && (sc1[24] || sc2[24]);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= 3'h0;
      irq_q    <= 1'b0;
    end else if (ce) begin
      status_q <= (status_q & ~stat_clr) | ev_set;
      irq_q    <= |(((status_q & ~stat_clr) | ev_set) & mask_q);
    end
  end

  assign hreadyout  = hreadyout_q;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_q;
  assign in_ready   = in_ready_q;
  assign out_result = out_q;
  assign irq        = irq_q;

endmodule : derived_channel_and_output_scaling
`default_nettype wire

// *** derived_channel_chk.sv ***
`include "derived_channel_consts.svh"
`default_nettype none
module derived_channel_chk #(
  parameter logic [23:0] SMALL_DIV = 24'h000004
) (
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire logic                         ce,
  input wire logic                         hsel,
  input wire logic [31:0]                  haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic [31:0]                  hwdata,
  input wire logic                         hready,
  input wire logic [31:0]                  hrdata,
  input wire derived_channel_pkg::sample_s in_sample,
  input wire logic                         in_ready,
  input wire derived_channel_pkg::result_s out_result,
  input wire logic                         irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic                         a_q, w_q, ord_q, mk_q;
  logic [7:0]                   ad_q;
  logic [1:0]                   op_q;
  derived_channel_pkg::sample_s s_q;
  wire logic take = in_sample.valid && in_ready;
  wire logic rd = hsel && htrans[1] && hready && !hwrite;
  wire logic signed [23:0] dv = ord_q ? s_q.ch1 : s_q.ch2;
  wire logic signed [24:0] sm = {1'h0, SMALL_DIV};
  wire logic tiny = dv < sm && dv > -sm;
  wire logic wr = a_q && w_q;
  // Mirror of the control and mask writes, sampled where the slave takes them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_q <= 1'h0;
      w_q <= 1'h0;
      ad_q <= 8'h00;
      op_q <= 2'h0;
      ord_q <= 1'h0;
      mk_q <= 1'h0;
      s_q <= '0;
    end else if (ce) begin
      a_q <= hsel && htrans[1] && hready;
      w_q <= hwrite;
      ad_q <= haddr[7:0];
      if (wr && ad_q == `DC_OFF_CTRL) op_q <= hwdata[1:0];
      if (wr && ad_q == `DC_OFF_CTRL) ord_q <= hwdata[2];
      if (wr && ad_q == `DC_OFF_MASK) mk_q <= hwdata[0];
      if (take) s_q <= in_sample;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RDZERO: assert property (!$past(rd) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  AST_LAT: assert property (take |-> ##[2:42] out_result.valid)
    else $error("no result after sample");
  AST_BUSY: assert property (take |=> !in_ready)
    else $error("ready stayed high after take");
  AST_PULSE: assert property (out_result.valid |=> !out_result.valid)
    else $error("result valid longer than one cycle");
  AST_TEMP: assert property (out_result.valid |->
    out_result.temp == s_q.temp) else $error("temperature altered");
  AST_SUB: assert property (out_result.valid && op_q[1] == op_q[0] |->
    out_result.ch3 == (ord_q ? s_q.ch2 - s_q.ch1 : s_q.ch1 - s_q.ch2))
    else $error("wrong difference");
  AST_RATIO: assert property (out_result.valid && op_q == 2'h2 &&
    s_q.ch1 == s_q.ch2 |-> out_result.ch3 == `DC_ONE_Q16)
    else $error("equal ratio not one");
  AST_DIVSAT: assert property (out_result.valid && op_q == 2'h1 && tiny
    |-> out_result.ch3 inside {`DC_SAT_POS, `DC_SAT_NEG})
    else $error("tiny divisor not saturated");
  AST_IRQ: assert property (out_result.valid && mk_q |-> irq)
    else $error("unmasked done without interrupt");
  C_DIV: cover property (out_result.valid && op_q == 2'h1);
  C_RATIO: cover property (out_result.valid && op_q == 2'h2);
  C_IRQ: cover property ($rose(irq));
endmodule : derived_channel_chk
bind derived_channel_and_output_scaling derived_channel_chk #(
  .SMALL_DIV(SMALL_DIV)
) i_derived_channel_chk (
  .clk, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .in_sample, .in_ready, .out_result, .irq
);
`default_nettype wire

// *** derived_channel_partner.sv ***
`default_nettype none
module derived_channel_partner (
  input  wire logic                         clk,
  input  wire logic                         in_ready,
  input  wire derived_channel_pkg::result_s out_result,
  output var  derived_channel_pkg::sample_s in_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  derived_channel_pkg::result_s last;
  initial in_sample = '0;
  // Conditioning side: holds the sample until taken, then shows inverted junk
  task automatic send(input derived_channel_pkg::sample_s s, input int gap);
    repeat (gap) @(posedge clk);
    s.valid = 1'h1;
    in_sample <= s;
    do @(posedge clk); while (!in_ready);
    in_sample <= ~s;
  endtask : send
  // Filter side has no backpressure: it only catches the one-cycle pulse
  task automatic recv();
    do @(posedge clk); while (!out_result.valid);
    last = out_result;
  endtask : recv
endmodule : derived_channel_partner
`default_nettype wire

// *** derived_channel_and_output_scaling_tb.sv ***
`include "derived_channel_consts.svh"
`default_nettype none
module derived_channel_and_output_scaling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SD = 32'h4;
  logic                         clk, rstn, ce, hsel, hwrite, od;
  logic                         hreadyout, hresp, in_ready, irq;
  logic [31:0]                  haddr, hwdata, hrdata, r, e3;
  logic [1:0]                   htrans, op;
  logic [2:0]                   hsize;
  logic [15:0]                  g1, g2;
  logic signed [23:0]           o1, o2, a, b;
  derived_channel_pkg::sample_s in_sample;
  derived_channel_pkg::result_s out_result;
  int                           error_cnt, comparisons, seed;
  derived_channel_and_output_scaling #(
    .SMALL_DIV(24'h000004)
  ) i_derived_channel_and_output_scaling (
    .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .in_sample(in_sample), .in_ready(in_ready),
    .out_result(out_result), .irq(irq));
  derived_channel_partner i_derived_channel_partner (.clk(clk),
    .in_ready(in_ready), .out_result(out_result), .in_sample(in_sample));
  always #12.5 clk = ~clk;
  task automatic cmp(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] ad, input int d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge clk); while (!hreadyout);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hreadyout);
    r = hrdata;
  endtask : bus
  function automatic logic [23:0] scl(input logic signed [23:0] x,
                                      input logic [15:0] g, input longint o);
    longint v;
    v = ((longint'(x) * longint'(g)) >>> 14) + o;
    if (v > 64'sh7FFFFF) v = 64'sh7FFFFF;
    if (v < -64'sh800000) v = -64'sh800000;
    return v[23:0];
  endfunction : scl
  function automatic logic [31:0] exp3(input logic signed [23:0] x, y);
    longint l, d;
    l = od ? y : x;
    d = od ? x : y;
    if (op == 2'h1) begin
      if (d < SD && d > -SD)
        return (l < 0) != (d < 0) ? `DC_SAT_NEG : `DC_SAT_POS;
      l = (l <<< 16) / d;
    end else if (op == 2'h2) begin
      if (x == y) return `DC_ONE_Q16;
      l = x < y ? (longint'(x) <<< 16) / y
                : 64'sh20000 - (longint'(y) <<< 16) / x;
    end else l = l - d;
    return l[31:0];
  endfunction : exp3
  task automatic run(input logic signed [23:0] x, y);
    derived_channel_pkg::result_s q;
    i_derived_channel_partner.send({1'h0, x, y, 24'($random(seed))},
                                   {$random(seed)} % 3);
    i_derived_channel_partner.recv();
    q = i_derived_channel_partner.last;
    e3 = exp3(x, y);
    cmp("ch1", {8'h0, scl(x, g1, o1)}, {8'h0, q.ch1});
    cmp("ch2", {8'h0, scl(y, g2, o2)}, {8'h0, q.ch2});
    cmp("ch3", e3, q.ch3);
  endtask : run
  task automatic mode(input int p, input logic o);
    op = 2'(p);
    od = o;
    bus(1'h1, `DC_OFF_CTRL, {o, op});
  endtask : mode
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    {clk, rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {ce, hsize, seed} = {4'hA, 32'h4548ADAB};
    {g1, g2, o1, o2, op, od} = {`DC_GAIN_ONE, `DC_GAIN_ONE, 51'h0};
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    bus(1'h0, `DC_OFF_GAIN2, 0);
    cmp("gain2", 32'h4000, r);
    cmp("hresp", 32'h0, {31'h0, hresp});
    bus(1'h0, 8'h24, 0);
    cmp("unmapped", 32'h0, r);
    for (int k = 0; k < 24; k++) begin
      mode(k % 4, (k / 4) % 2);
      a = 24'({$random(seed)} % 16000 + 100);
      b = k < 4 ? a : 24'({$random(seed)} % 16000 + 100);
      run(a, b);
    end
    mode(1, 0);
    run(24'h1000, 24'h2);
    run(24'h1000, 24'h0);
    run(24'h1000, 24'h4);
    mode(1, 1);
    run(24'h3, 24'h1000);
    mode(0, 0);
    run(24'hFFFFF0, 24'h10);
    $display("test operations done");
    bus(1'h1, `DC_OFF_GAIN1, 32'h6000);
    bus(1'h1, `DC_OFF_OFFS1, 32'h5);
    bus(1'h1, `DC_OFF_GAIN2, 32'h2000);
    bus(1'h1, `DC_OFF_OFFS2, 32'hFFFFFD);
    run(a, b);
    bus(1'h1, `DC_OFF_COMMIT, 32'h1);
    {g1, o1, g2, o2} = {16'h6000, 24'h5, 16'h2000, 24'hFFFFFD};
    run(a, b);
    bus(1'h1, `DC_OFF_MASK, 32'h4);
    run(24'h700000, b);
    cmp("irq", 32'h1, {31'h0, irq});
    bus(1'h0, `DC_OFF_STATUS, 0);
    cmp("status", 32'h1, {31'h0, r[2]});
    bus(1'h1, `DC_OFF_STATUS, 32'h7);
    bus(1'h1, `DC_OFF_MASK, 32'h1);
    cmp("irq clear", 32'h0, {31'h0, irq});
    run(a, a);
    cmp("irq done", 32'h1, {31'h0, irq});
    bus(1'h1, `DC_OFF_MASK, 32'h0);
    bus(1'h0, `DC_OFF_RESULT, 0);
    cmp("irq masked", 32'h0, {31'h0, irq});
    cmp("result", e3, r);
    $display("test scaling and interrupt done");
    ce <= 1'h0;
    repeat (5) @(posedge clk);
    cmp("frozen", e3, out_result.ch3);
    ce <= 1'h1;
    bus(1'h0, `DC_OFF_OFFS1, 0);
    cmp("offs1", 32'h5, r);
    $display("test clock enable done");
    summarize();
  end
endmodule : derived_channel_and_output_scaling_tb
`default_nettype wire
